/* File: logic/rra_pkg.sv */
// constants and types shared by the rail register access logic
`default_nettype none

package rra_pkg;

  // register addresses of the first rail; later rails repeat every page
  localparam logic [7:0] RAIL1_STATUS_ADDR  = 8'h28;
  localparam logic [7:0] RAIL1_OFF_ADDR     = 8'h30;
  localparam logic [7:0] RAIL1_LEVEL_LO_ADDR = 8'h32;
  localparam logic [7:0] RAIL1_LEVEL_HI_ADDR = 8'h33;

  // register address split: page number above, in-page offset below
  localparam int unsigned PAGE_MSB = 7;
  localparam int unsigned PAGE_LSB = 5;
  localparam int unsigned OFS_MSB  = 4;
  localparam logic [2:0]  DEVICE_PAGE = 3'h0;

  // in-page offsets derived from the first rail's addresses
  localparam logic [4:0] OFS_STATUS   = RAIL1_STATUS_ADDR[OFS_MSB:0];
  localparam logic [4:0] OFS_OFF      = RAIL1_OFF_ADDR[OFS_MSB:0];
  localparam logic [4:0] OFS_LEVEL_LO = RAIL1_LEVEL_LO_ADDR[OFS_MSB:0];
  localparam logic [4:0] OFS_LEVEL_HI = RAIL1_LEVEL_HI_ADDR[OFS_MSB:0];

  // status byte fields
  localparam int unsigned ST_IN_REG_BIT      = 0;
  localparam int unsigned ST_OVERCURRENT_BIT = 1;
  localparam int unsigned ST_OVERVOLTAGE_BIT = 2;
  localparam int unsigned ST_UV_BIT          = 3;

  // off control fields
  localparam int unsigned OFF_BIT  = 0;
  localparam int unsigned MODE_BIT = 1;

  // output level code
  localparam int unsigned LEVEL_W       = 10;
  localparam int unsigned LEVEL_HI_W    = LEVEL_W - 8;
  localparam int unsigned LEVEL_STEP_UV = 2500;   // microvolts per code step at the feedback node

  // bus protocol
  localparam logic [6:0]  BUS_ADDR_DEFAULT = 7'h55;
  localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
  localparam logic [7:0]  UNMAPPED_READ    = 8'h00;

  // bus sequencer states
  typedef enum logic [3:0] {
    RRA_IDLE      = 4'b0000,
    RRA_ADDR      = 4'b0001,
    RRA_ADDR_ACK  = 4'b0010,
    RRA_REG       = 4'b0011,
    RRA_REG_ACK   = 4'b0100,
    RRA_WDATA     = 4'b0101,
    RRA_WDATA_ACK = 4'b0110,
    RRA_RDATA     = 4'b0111,
    RRA_MACK      = 4'b1000
  } rra_state_e;

endpackage

`default_nettype wire

/* File: logic/rra_i2c_target.sv */
// bus target with paged per-rail status, off control and output level registers
//
// Functional notes
// R1: single or multi-byte writes and reads follow one register address phase
// R2: received register address is the first accessed; later bytes go upward
// R3: write bytes land in incrementing registers until stop
// R4: master writes start address, then repeated start with read direction
// R5: read returns consecutive bytes until master answers not-acknowledge
// R6: status byte at 0x28 for rail one, 0x48, 0x68 for later rails
// R7: status holds in-regulation level plus overcurrent, overvoltage, input-undervoltage flags
// R8: fault flags are sticky, even for momentary faults, until read
// R9: all fault flags of a rail clear on the next read of that rail
// R10: enable register bit 0: zero requests rail on, one requests off
// R11: enable register bit 1 is stored but has no effect
// R12: rail enabled only while enable pin high and off bit zero
// R13: register access works normally while the rail is disabled
// R14: 10-bit level code: low byte at 0x32, bits 9..8 at 0x33
// R15: master writes level code as one two-byte write
// R16: level code times 2.5 divided by 1000 gives volts
// R17: level code sets the feedback-node target, not the divided-up rail voltage
// R18: 256 addresses split into eight pages; page 0 device, 1..7 rails
// R19: page in address bits 7..5, offset in bits 4..0
// R20: answers 7-bit bus address, default 0x55; address LSB 0 write, 1 read
// R21: always a bus target, never starts transactions
`default_nettype none

module rra_i2c_target #(
  parameter int unsigned NUM_RAILS = 7,
  parameter logic [6:0]  BUS_ADDR  = rra_pkg::BUS_ADDR_DEFAULT
) (
  input  wire logic                                        core_clk_i,
  input  wire logic                                        rst_b_i,
  input  wire logic                                        scl_i,
  input  wire logic                                        sda_i,
  output var  logic                                        sda_o,
  output var  logic                                        sda_oe_o,
  input  wire logic [NUM_RAILS-1:0]                        en_pin_i,
  input  wire logic [NUM_RAILS-1:0]                        rail_in_regulation_flag_i,
  input  wire logic [NUM_RAILS-1:0]                        overcurrent_fault_flag_i,
  input  wire logic [NUM_RAILS-1:0]                        overvoltage_fault_flag_i,
  input  wire logic [NUM_RAILS-1:0]                        input_undervoltage_fault_flag_i,
  output var  logic [NUM_RAILS-1:0]                        rail_enable_o,
  output var  logic [NUM_RAILS-1:0][rra_pkg::LEVEL_W-1:0]  level_code_o
);
  import rra_pkg::*;

  // pages past the last rail decode to nothing: writes are acked and dropped
  localparam logic [2:0] LAST_PAGE = 3'(NUM_RAILS);

  // every flip-flop of the block lives in this one struct
  typedef struct packed {
    rra_state_e                          state;
    logic [3:0]                          cnt;
    logic [7:0]                          sh;
    logic [7:0]                          tx;
    logic [7:0]                          ptr;
    logic                                more;
    logic                                sda_oe;
    logic                                scl_m;
    logic                                scl_s;
    logic                                scl_p;
    logic                                sda_m;
    logic                                sda_s;
    logic                                sda_p;
    logic [NUM_RAILS-1:0]                pin_m;
    logic [NUM_RAILS-1:0]                pin_s;
    logic [NUM_RAILS-1:0][3:0]           flt_m;
    logic [NUM_RAILS-1:0][3:0]           flt_s;
    logic [NUM_RAILS-1:0][2:0]           sticky;
    logic [NUM_RAILS-1:0]                off;
    logic [NUM_RAILS-1:0]                mode;
    logic [NUM_RAILS-1:0][7:0]           lvl_lo;
    logic [NUM_RAILS-1:0][LEVEL_HI_W-1:0] lvl_hi;
    logic [NUM_RAILS-1:0][LEVEL_W-1:0]   lvl_act;
    logic [NUM_RAILS-1:0]                en;
  } rra_state_s;

  rra_state_s q;
  rra_state_s d;

  // decoded view of the register pointer
  logic [2:0] page;
  logic [4:0] ofs;
  logic       rail_hit;
  logic [2:0] rail;
  logic [7:0] rd_byte;

  // bus line events, seen only on synchronised copies
  // the delayed copy costs one cycle of latency but gives clean edges
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = q.scl_s & ~q.scl_p;
  assign scl_fall  = ~q.scl_s & q.scl_p;
  // start and stop are data edges while the clock line stays high
  assign bus_start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign bus_stop  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

  // page and offset split of the pointer
  // R19: page and offset fields
  assign page = q.ptr[PAGE_MSB:PAGE_LSB];
  assign ofs  = q.ptr[OFS_MSB:0];
  // R18: page 0 device, pages 1..N rails
  assign rail_hit = (page != DEVICE_PAGE) && (page <= LAST_PAGE);
  assign rail     = page - 3'h1;

  // read data for the byte under the pointer; unmapped addresses read zero
  always_comb begin
    rd_byte = UNMAPPED_READ;
    if (rail_hit) begin
      // R6: status at page offset 0x08
      if (ofs == OFS_STATUS) begin
        rd_byte = 8'h00;
        // the level bit is live, so a read shows it as of the byte load
        // R7: in-regulation level live, fault flags sticky
        rd_byte[ST_IN_REG_BIT]      = q.flt_s[rail][0];
        rd_byte[ST_OVERCURRENT_BIT] = q.sticky[rail][0];
        rd_byte[ST_OVERVOLTAGE_BIT] = q.sticky[rail][1];
        rd_byte[ST_UV_BIT]     = q.sticky[rail][2];
      end else if (ofs == OFS_OFF) begin
        rd_byte           = 8'h00;
        rd_byte[OFF_BIT]  = q.off[rail];
        rd_byte[MODE_BIT] = q.mode[rail];
      end else if (ofs == OFS_LEVEL_LO) begin
        rd_byte = q.lvl_lo[rail];
      end else if (ofs == OFS_LEVEL_HI) begin
        rd_byte = {6'h00, q.lvl_hi[rail]};
      end
    end
  end

  // next state of the whole block
  always_comb begin
    logic load;
    logic wr;
    d    = q;
    load = 1'b0;
    wr   = 1'b0;

    // two-flop synchronisers; the first stage feeds only the second
    d.scl_m = scl_i;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = sda_i;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.pin_m = en_pin_i;
    d.pin_s = q.pin_m;
    for (int i = 0; i < NUM_RAILS; i++) begin
      d.flt_m[i] = {input_undervoltage_fault_flag_i[i], overvoltage_fault_flag_i[i],
                    overcurrent_fault_flag_i[i], rail_in_regulation_flag_i[i]};
    end
    d.flt_s = q.flt_m;

    // no clock stretching: each answer must settle within the master's low
    // phase, about three clocks after the clock line falls
    // R21: target only; sda is only ever released or pulled low
    case (q.state)
      RRA_IDLE: begin
        d.sda_oe = 1'b0;
      end
      RRA_ADDR, RRA_REG, RRA_WDATA: begin
        if (scl_rise) begin
          d.sh  = {q.sh[6:0], q.sda_s};
          d.cnt = q.cnt + 4'h1;
        end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
          d.cnt = 4'h0;
          if (q.state == RRA_ADDR) begin
            // R20: match the 7-bit address, keep the direction bit
            if (q.sh[7:1] == BUS_ADDR) begin
              d.more   = q.sh[0];
              d.sda_oe = 1'b1;
              d.state  = RRA_ADDR_ACK;
            end else begin
              d.state = RRA_IDLE;
            end
          end else if (q.state == RRA_REG) begin
            // R2: the received address starts the sequence
            d.ptr    = q.sh;
            d.sda_oe = 1'b1;
            d.state  = RRA_REG_ACK;
          end else begin
            // R3: store and step on to the next register
            wr       = 1'b1;
            d.sda_oe = 1'b1;
            d.state  = RRA_WDATA_ACK;
          end
        end
      end
      RRA_ADDR_ACK: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          if (q.more) begin
            // R4: read direction after a repeated start sends at once
            load = 1'b1;
          end else begin
            d.state = RRA_REG;
          end
        end
      end
      RRA_REG_ACK, RRA_WDATA_ACK: begin
        // R1: any number of data bytes may follow
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.state  = RRA_WDATA;
        end
      end
      RRA_RDATA: begin
        // each new bit goes out on the clock fall, inside the low phase
        if (scl_rise) begin
          d.cnt = q.cnt + 4'h1;
        end else if (scl_fall) begin
          if (q.cnt == BITS_PER_BYTE) begin
            d.sda_oe = 1'b0;
            d.state  = RRA_MACK;
          end else begin
            d.tx     = {q.tx[6:0], 1'b0};
            d.sda_oe = ~q.tx[6];
          end
        end
      end
      RRA_MACK: begin
        // the master's answer is taken on the clock rise, while data is steady
        // R5: a not-acknowledge ends the read
        if (scl_rise) begin
          d.more = ~q.sda_s;
          if (q.sda_s) begin
            d.state = RRA_IDLE;
          end
        end else if (scl_fall && q.more) begin
          load = 1'b1;
        end
      end
      default: begin
        d.state = RRA_IDLE;
      end
    endcase

    // load the next read byte and drive its first bit
    // the byte leaves with the flags as they stood; a fault in this very
    // cycle is ored back in below, so it is never lost
    if (load) begin
      d.tx     = rd_byte;
      d.ptr    = q.ptr + 8'h01;
      d.sda_oe = ~rd_byte[7];
      d.cnt    = 4'h0;
      d.state  = RRA_RDATA;
      // R9: any read of a rail clears its fault flags
      if (rail_hit) begin
        d.sticky[rail] = 3'b000;
      end
    end

    // register write; accepted whether or not the rail runs
    // the pointer steps on unmapped addresses too, so long writes walk on
    // R13: access independent of enable
    if (wr) begin
      d.ptr = q.ptr + 8'h01;
      if (rail_hit) begin
        if (ofs == OFS_OFF) begin
          // R10: off bit, one requests off
          d.off[rail]  = q.sh[OFF_BIT];
          // R11: mode bit kept for readback only
          d.mode[rail] = q.sh[MODE_BIT];
        end else if (ofs == OFS_LEVEL_LO) begin
          d.lvl_lo[rail] = q.sh;
        end else if (ofs == OFS_LEVEL_HI) begin
          // R14: high bits join the low byte held before
          // R15: code moves only when the high byte lands, so no torn word
          d.lvl_hi[rail]  = q.sh[LEVEL_HI_W-1:0];
          d.lvl_act[rail] = {q.sh[LEVEL_HI_W-1:0], q.lvl_lo[rail]};
        end
      end
    end

    // start and stop win over any bit-level activity
    if (bus_stop) begin
      d.state  = RRA_IDLE;
      d.sda_oe = 1'b0;
    end else if (bus_start) begin
      d.state  = RRA_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end

    // R8: faults set sticky flags after any clear, so a new fault wins
    for (int i = 0; i < NUM_RAILS; i++) begin
      d.sticky[i] = d.sticky[i] | q.flt_s[i][3:1];
    end

    // R12: pin high and off bit clear
    d.en = q.pin_s & ~q.off;
  end

  // the only clocked process; reset state is zero apart from the line samplers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q       <= '0;
      // line samplers start at the idle-high bus level, so the release of
      // reset never looks like a clock rise or a stop condition
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops apart from sda_o, which is tied low; pulled-low data only
  // the pin only ever sinks; the bus pull-up gives the high level
  assign sda_o         = 1'b0;
  assign sda_oe_o      = q.sda_oe;
  assign rail_enable_o = q.en;
  // R16: one code step is LEVEL_STEP_UV at the regulation point
  // R17: regulation treats this as the feedback-node target
  assign level_code_o  = q.lvl_act;

endmodule

`default_nettype wire

/* File: tb/rra_i2c_target_monitor.sv */
// assertion checker for the rail register access bus target
`default_nettype none
module rra_i2c_target_monitor #(
  parameter int unsigned NUM_RAILS = 7
) (
  input wire logic                                       core_clk_i,
  input wire logic                                       rst_b_i,
  input wire logic                                       scl_i,
  input wire logic                                       sda_o,
  input wire logic                                       sda_oe_o,
  input wire logic [NUM_RAILS-1:0]                       en_pin_i,
  input wire logic [NUM_RAILS-1:0]                       rail_enable_o,
  input wire logic [NUM_RAILS-1:0][rra_pkg::LEVEL_W-1:0] level_code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import rra_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // pin and bus relations
  property p_pull_only; sda_o == 1'b0; endproperty
  a_pull_only: assert property (p_pull_only) else $error("sda value not zero");
  property p_en_pin; (rail_enable_o & ~$past(en_pin_i, 3)) == '0; endproperty
  a_en_pin: assert property (p_en_pin) else $error("rail on without pin");
  // the data pin moves only in the low phase, so no false start or stop
  property p_oe_move; $changed(sda_oe_o) |-> !$past(scl_i, 3); endproperty
  a_oe_move: assert property (p_oe_move) else $error("sda moved late");
  property p_oe_hold; scl_i && $past(scl_i, 2) |-> $stable(sda_oe_o); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sda moved in high phase");
  property p_oe_release; $rose(sda_oe_o) |-> ##[1:80] !sda_oe_o; endproperty
  a_oe_release: assert property (p_oe_release) else $error("sda held too long");
  // level code commits on a byte boundary, then the byte is acked
  property p_lvl_low; $changed(level_code_o) |-> !$past(scl_i); endproperty
  a_lvl_low: assert property (p_lvl_low) else $error("level moved in high phase");
  property p_lvl_ack; $changed(level_code_o) |-> ##[0:8] sda_oe_o; endproperty
  a_lvl_ack: assert property (p_lvl_ack) else $error("level byte not acked");
  property p_lvl_gap; $changed(level_code_o) |=> $stable(level_code_o) [*8]; endproperty
  a_lvl_gap: assert property (p_lvl_gap) else $error("level moved twice in a byte");
  c_level: cover property ($changed(level_code_o));
  c_rail_on: cover property ($rose(rail_enable_o[0]));
  c_ack: cover property ($rose(sda_oe_o));
endmodule
bind rra_i2c_target rra_i2c_target_monitor #(.NUM_RAILS(NUM_RAILS)) rra_i2c_target_monitor_inst (
  .core_clk_i, .rst_b_i, .scl_i, .sda_o, .sda_oe_o, .en_pin_i, .rail_enable_o, .level_code_o);
`default_nettype wire

/* File: tb/rra_bm.sv */
// bus master model on the far side of the two-wire bus
`default_nettype none
module rra_bm (
  input  wire logic sda_oe_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda_m = 1'b1;
  initial scl_o = 1'b1;
  // pull-up wins unless someone pulls low
  assign sda_o = sda_m & ~sda_oe_i;
  // low phase 250 ns outlasts the target's 150 ns answer delay
  task automatic bit_x(input logic b, output logic s);
    #150 sda_m = b;
    #100 scl_o = 1'b1;
    #140 s = sda_o;
    #10 scl_o = 1'b0;
  endtask
  task automatic start();
    #150 sda_m = 1'b1;
    #100 scl_o = 1'b1;
    #150 sda_m = 1'b0;
    #150 scl_o = 1'b0;
  endtask
  task automatic stop();
    #150 sda_m = 1'b0;
    #100 scl_o = 1'b1;
    #150 sda_m = 1'b1;
    #150;
  endtask
  // byte out, msb first, returns acknowledge
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  // byte in, not-acknowledge marks the last
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, s);
  endtask
endmodule
`default_nettype wire

/* File: tb/rra_i2c_target_test.sv */
// self-checking bench for the rail register access bus target
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module rra_i2c_target_test;
  timeunit 1ns;
  timeprecision 1ns;
  import rra_pkg::*;
  localparam logic [7:0] WA = {BUS_ADDR_DEFAULT, 1'b0};
  int                       num_errors = 0;
  int                       num_checks = 0;
  logic                     core_clk_i = 1'b0;
  logic                     rst_b_i = 1'b0;
  logic [6:0]               en_pin_i = 7'h7F;
  logic [6:0]               in_reg = 7'h7F;
  logic [6:0]               oc = '0;
  logic [6:0]               ov = '0;
  logic [6:0]               uv = '0;
  wire logic                scl;
  wire logic                sda;
  wire logic                sda_oe;
  wire logic [6:0]          rail_en;
  wire logic [6:0][LEVEL_W-1:0] level;
  rra_bm rra_bm_inst (.sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  rra_i2c_target rra_i2c_target_inst (.core_clk_i, .rst_b_i, .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .en_pin_i, .rail_in_regulation_flag_i(in_reg), .overcurrent_fault_flag_i(oc),
    .overvoltage_fault_flag_i(ov), .input_undervoltage_fault_flag_i(uv), .rail_enable_o(rail_en),
    .level_code_o(level));
  // register write: one address phase, then bytes
  task automatic wr(input logic [7:0] ra, input logic [7:0] q[$]);
    logic a;
    rra_bm_inst.start();
    rra_bm_inst.put(WA, a);
    `CHK("addr ack", 1'b1, a)
    rra_bm_inst.put(ra, a);
    foreach (q[i]) rra_bm_inst.put(q[i], a);
    `CHK("data ack", 1'b1, a)
    rra_bm_inst.stop();
  endtask
  // register read through a repeated start
  task automatic rd(input logic [7:0] ra, input int n, output logic [7:0] q[$]);
    logic a;
    logic [7:0] d;
    q = {};
    rra_bm_inst.start();
    rra_bm_inst.put(WA, a);
    rra_bm_inst.put(ra, a);
    rra_bm_inst.start();
    rra_bm_inst.put(WA | 8'h01, a);
    `CHK("read ack", 1'b1, a)
    for (int i = 0; i < n; i++) begin
      rra_bm_inst.get(i == n - 1, d);
      q.push_back(d);
    end
    rra_bm_inst.stop();
  endtask
  // two-byte level words on the first and last rail pages
  task automatic t_level();
    logic [7:0] q[$];
    wr(RAIL1_LEVEL_LO_ADDR, '{8'h34, 8'h01});
    `CHK("level rail1", 10'h134, level[0])
    wr(8'hF2, '{8'hFF, 8'h03});
    `CHK("level rail7", 10'h3FF, level[6])
    rd(8'hF2, 2, q);
    `CHK("read lo", 8'hFF, q[0])
    `CHK("read hi", 8'h03, q[1])
  endtask
  // reset in mid-run: registers drop to zero, the rail follows the pin again
  task automatic t_reset();
    rst_b_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    `CHK("reset level", 10'h000, level[0])
    `CHK("reset rail off", 7'h00, rail_en)
    rst_b_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    `CHK("reset rail on", 7'h7F, rail_en)
    `CHK("reset level7", 10'h000, level[6])
  endtask
  // off bit against the pin; access while the rail is off
  task automatic t_enable();
    logic [7:0] q[$];
    `CHK("enable", 7'h7F, rail_en)
    wr(RAIL1_OFF_ADDR, '{8'h01});
    `CHK("off bit", 7'h7E, rail_en)
    wr(RAIL1_OFF_ADDR, '{8'h02});
    `CHK("mode bit", 7'h7F, rail_en)
    en_pin_i[0] = 1'b0;
    repeat (4) @(negedge core_clk_i);
    `CHK("pin low", 7'h7E, rail_en)
    wr(RAIL1_OFF_ADDR, '{8'h03});
    rd(RAIL1_OFF_ADDR, 1, q);
    `CHK("read while off", 8'h03, q[0])
    en_pin_i[0] = 1'b1;
    wr(RAIL1_OFF_ADDR, '{8'h00});
    `CHK("back on", 7'h7F, rail_en)
  endtask
  // one-cycle faults stay until the rail is read
  task automatic t_fault();
    logic [7:0] q[$];
    in_reg = 7'h02;
    oc[1] = 1'b1;
    uv[1] = 1'b1;
    ov[2] = 1'b1;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    oc = '0;
    uv = '0;
    ov = '0;
    repeat (4) @(negedge core_clk_i);
    rd(8'h48, 1, q);
    `CHK("rail2 faults", 8'h0B, q[0])
    rd(8'h48, 1, q);
    `CHK("rail2 cleared", 8'h01, q[0])
    rd(8'h68, 1, q);
    `CHK("rail3 faults", 8'h04, q[0])
  endtask
  // foreign bus address and the empty device page
  task automatic t_refuse();
    logic a;
    logic [7:0] q[$];
    rra_bm_inst.start();
    rra_bm_inst.put(WA ^ 8'h02, a);
    `CHK("foreign addr", 1'b0, a)
    rra_bm_inst.stop();
    rd(8'h08, 1, q);
    `CHK("page0", UNMAPPED_READ, q[0])
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  // the whole run needs about 185 us of bus traffic
  initial begin
    #2000000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (6) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    repeat (6) @(negedge core_clk_i);
    t_level();
    t_reset();
    t_enable();
    t_fault();
    t_refuse();
    conclude();
  end
endmodule
`default_nettype wire
